// *** hw/debug_pin_cfg.svh ***
// constants for the debug pin assignment block
// assumes inclusion by bare name from the package and the checker
`ifndef DEBUG_PIN_CFG_SVH
`define DEBUG_PIN_CFG_SVH

// register byte addresses
`define REMAP_ADDR 32'h40010004
`define IDENT_ADDR 32'hE0042000

// debug pin config field
`define CFG_LSB 24
`define CFG_MSB 26
`define CFG_RST 3'h0
`define CFG_FULL 3'h0
`define CFG_NO_TRST 3'h1
`define CFG_SW_ONLY 3'h2
`define CFG_NONE 3'h4

// identification register fields
`define REV_LSB 16
`define REV_MSB 31
`define DEVC_MSB 11

// pin indices
`define PIN_TMS 0
`define PIN_TCK 1
`define PIN_TDI 2
`define PIN_TDO 3
`define PIN_TRST 4

// pull patterns while debug owns the pins, and gpio reset equivalents
`define DBG_PU 5'h15
`define DBG_PD 5'h02
`define GPIO_RST_PU 5'h15
`define GPIO_RST_PD 5'h02

// scan chain
`define BS_IR_W 5
`define DBG_IR_W 4
`define BS_IR_CAP 5'h01
`define DBG_IR_CAP 4'h1

// serial wire switch sequence
`define SEQ_ONES_MIN 6'h33
`define SEQ_PATTERN 16'h79E7
`define SEQ_LEN 5'h10

`endif

// *** hw/debug_pin_pkg.sv ***
// types for the debug pin assignment block
// assumes debug_pin_cfg.svh is on the include path
package debug_pin_pkg;
    `include "debug_pin_cfg.svh"

    typedef enum logic [3:0] {
        tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
        tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir,
        tap_shift_ir, tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
    } tap_e;

    typedef enum logic [1:0] {seq_count, seq_pattern, seq_tail} seq_e;

    // per-pin pad controls, bit index = pin index
    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
        logic [4:0] pu;
        logic [4:0] pd;
    } pad_ctl_s;

    // gated debug inputs toward the core
    typedef struct packed {
        logic trst_n;
        logic tdi;
        logic tms;
        logic tck;
    } core_in_s;
endpackage : debug_pin_pkg

// *** hw/debug_pin_assign.sv ***
// debug pin sharing, two chained test access ports, switch to serial wire
// assumes a peripheral bridge on clock_in and the probe clocking the test clock pin
`timescale 1ns/100ps

// How it works
// - nrst_in or system reset gives all five pins to debug; test reset does not
// - 3-bit config field at remap bits 26:24
// - config resets to 000, full assignment
// - mode 001 releases only test reset pin
// - mode 010 keeps only mode select and clock
// - mode 100 releases all five pins
// - reads no wait, full buffer write waits one
// - deactivation cycle one ties core debug inputs
// - cycle two hands pad controls to gpio
// - mode select, data in and test reset pulled up, clock pulled down
// - released pins keep equivalent gpio pull state
// - gpio writes ignored while debug owns pin
// - chain 5-bit and 4-bit instruction taps
// - bypassed tap adds one data bit
// - serial wire forces boundary tap mode high
// - identification read only, readable under system reset
// - revision 31:16, device 11:0, 15:12 reserved
// - detect ones, 16-bit pattern, ones sequence
// - scan port active until serial wire selected
module debug_pin_assign
    import debug_pin_pkg::*;
#(
    parameter logic [15:0] REV_CODE = 16'h0001, // arbitrary value
    parameter logic [11:0] DEV_CODE = 12'h001 // arbitrary value
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic sys_rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic bridge_full_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [4:0] pin_in,
    input wire pad_ctl_s gpio_ctl_in,
    output pad_ctl_s pad_ctl_out,
    output logic [4:0] debug_owns_out,
    output core_in_s core_in_out,
    output logic sw_mode_out,
    input wire logic test_clk_in,
    input wire logic bs_dr_tdo_in,
    input wire logic dbg_dr_tdo_in,
    output logic [`BS_IR_W-1:0] bs_ir_out,
    output logic [`DBG_IR_W-1:0] dbg_ir_out,
    output logic tdo_out,
    output logic tdo_oe_out
);

    // which pins stay with debug for a config value
    function automatic logic [4:0] debug_pins(input logic [2:0] cfg);
        logic [4:0] m;
        m = 5'h1F;
        case (cfg)
            `CFG_NO_TRST: m = 5'h0F;
            `CFG_SW_ONLY: m = 5'h03;
            `CFG_NONE: m = 5'h00;
            default: m = 5'h1F;
        endcase
        return m;
    endfunction : debug_pins

    function automatic tap_e tap_next(input tap_e s, input logic tms);
        tap_e n;
        n = s;
        case (s)
            tap_reset: n = tms ? tap_reset : tap_idle;
            tap_idle: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_dr: n = tms ? tap_sel_ir : tap_cap_dr;
            tap_cap_dr: n = tms ? tap_exit1_dr : tap_shift_dr;
            tap_shift_dr: n = tms ? tap_exit1_dr : tap_shift_dr;
            tap_exit1_dr: n = tms ? tap_upd_dr : tap_pause_dr;
            tap_pause_dr: n = tms ? tap_exit2_dr : tap_pause_dr;
            tap_exit2_dr: n = tms ? tap_upd_dr : tap_shift_dr;
            tap_upd_dr: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_ir: n = tms ? tap_reset : tap_cap_ir;
            tap_cap_ir: n = tms ? tap_exit1_ir : tap_shift_ir;
            tap_shift_ir: n = tms ? tap_exit1_ir : tap_shift_ir;
            tap_exit1_ir: n = tms ? tap_upd_ir : tap_pause_ir;
            tap_pause_ir: n = tms ? tap_exit2_ir : tap_pause_ir;
            tap_exit2_ir: n = tms ? tap_upd_ir : tap_shift_ir;
            default: n = tms ? tap_sel_dr : tap_idle;
        endcase
        return n;
    endfunction : tap_next

    // ---------------- system clock domain ----------------
    logic sys_q1_r, sys_q2_r;
    logic [4:0] pin_q1_r, pin_q2_r;
    logic sw_q1_r, sw_q2_r;
    logic [2:0] cfg_r;
    logic [4:0] tie_r;
    logic [4:0] owns_r;
    logic wait_done_r;
    logic sw_sel_r;

    wire logic rst_any = !nrst_in || !sys_q2_r;
    wire logic setup = psel_in && !penable_in;
    wire logic access = psel_in && penable_in && pready_out;
    wire logic hit_remap = paddr_in == `REMAP_ADDR;
    wire logic hit_ident = paddr_in == `IDENT_ADDR;
    wire logic [4:0] want = debug_pins(cfg_r);

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sys_q1_r <= 1'b0;
            sys_q2_r <= 1'b0;
            pin_q1_r <= 5'h00;
            pin_q2_r <= 5'h00;
            sw_q1_r <= 1'b0;
            sw_q2_r <= 1'b0;
        end else begin
            sys_q1_r <= sys_rst_n_in;
            sys_q2_r <= sys_q1_r;
            pin_q1_r <= pin_in;
            pin_q2_r <= pin_q1_r;
            sw_q1_r <= sw_sel_r;
            sw_q2_r <= sw_q1_r;
        end
    end

    // config field, cleared by either reset
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            cfg_r <= `CFG_RST;
        end else if (access && pwrite_in && hit_remap) begin
            cfg_r <= pwdata_in[`CFG_MSB:`CFG_LSB];
        end
    end

    // two-step release: tie core inputs first, then hand pad to gpio
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            tie_r <= 5'h00;
            owns_r <= 5'h1F;
        end else begin
            tie_r <= ~want;
            owns_r <= want | ~tie_r;
        end
    end

    // bus answer; ident path ignores system reset
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
            wait_done_r <= 1'b0;
        end else if (setup) begin
            pready_out <= !(pwrite_in && bridge_full_in);
            pslverr_out <= !(hit_remap || (hit_ident && !pwrite_in));
            wait_done_r <= 1'b0;
            prdata_out <= 32'h0;
            if (hit_remap) begin
                prdata_out[`CFG_MSB:`CFG_LSB] <= cfg_r;
            end else if (hit_ident) begin
                prdata_out <= {REV_CODE, 4'h0, DEV_CODE};
            end
        end else if (psel_in && penable_in && !pready_out && !wait_done_r) begin
            pready_out <= 1'b1;
            wait_done_r <= 1'b1;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // pad controls; gpio values pass only on released pins
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            pad_ctl_out.out <= 5'h00;
            pad_ctl_out.oe <= 5'h00;
            pad_ctl_out.pu <= `DBG_PU;
            pad_ctl_out.pd <= `DBG_PD;
        end else begin
            pad_ctl_out.out <= gpio_ctl_in.out & ~owns_r;
            pad_ctl_out.oe <= gpio_ctl_in.oe & ~owns_r;
            pad_ctl_out.pu <= (`DBG_PU & owns_r) | (gpio_ctl_in.pu & ~owns_r);
            pad_ctl_out.pd <= (`DBG_PD & owns_r) | (gpio_ctl_in.pd & ~owns_r);
        end
    end

    // core facing debug inputs
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            core_in_out <= '{trst_n: 1'b1, tdi: 1'b1, tms: 1'b1, tck: 1'b0};
            debug_owns_out <= 5'h1F;
            sw_mode_out <= 1'b0;
        end else begin
            core_in_out.trst_n <= tie_r[`PIN_TRST] ? 1'b1 : pin_q2_r[`PIN_TRST];
            core_in_out.tdi <= tie_r[`PIN_TDI] ? 1'b1 : pin_q2_r[`PIN_TDI];
            core_in_out.tms <= tie_r[`PIN_TMS] ? 1'b1 : pin_q2_r[`PIN_TMS];
            core_in_out.tck <= tie_r[`PIN_TCK] ? 1'b0 : pin_q2_r[`PIN_TCK];
            debug_owns_out <= owns_r;
            sw_mode_out <= sw_q2_r;
        end
    end

    // ---------------- test clock domain ----------------
    logic lrst_q1_r, lrst_q2_r;
    logic [4:0] lown_q1_r, lown_q2_r;
    seq_e seq_r;
    logic [5:0] ones_r;
    logic [4:0] bits_r;
    logic [15:0] pat_r;
    tap_e bs_st_r, dbg_st_r;
    logic [`BS_IR_W-1:0] bs_sh_r;
    logic [`DBG_IR_W-1:0] dbg_sh_r;
    logic bs_byp_r, dbg_byp_r;

    wire logic tms_l = lown_q2_r[`PIN_TMS] ? pin_in[`PIN_TMS] : 1'b1;
    wire logic tdi_l = lown_q2_r[`PIN_TDI] ? pin_in[`PIN_TDI] : 1'b1;
    wire logic trst_l = lown_q2_r[`PIN_TRST] ? pin_in[`PIN_TRST] : 1'b1;
    wire logic lrst = !lrst_q2_r || !trst_l;
    wire logic bs_tms = tms_l || sw_sel_r;
    wire logic bs_byp = &bs_ir_out;
    wire logic dbg_byp = &dbg_ir_out;
    wire logic bs_dr = bs_byp ? bs_byp_r : bs_dr_tdo_in;
    wire logic dbg_dr = dbg_byp ? dbg_byp_r : dbg_dr_tdo_in;

    always_ff @(posedge test_clk_in) begin
        lrst_q1_r <= nrst_in;
        lrst_q2_r <= lrst_q1_r;
        lown_q1_r <= owns_r;
        lown_q2_r <= lown_q1_r;
    end

    // switch sequence detector
    always_ff @(posedge test_clk_in) begin
        if (lrst) begin
            seq_r <= seq_count;
            ones_r <= 6'h00;
            bits_r <= 5'h00;
            pat_r <= 16'h0000;
            sw_sel_r <= 1'b0;
        end else begin
            case (seq_r)
                seq_count: begin
                    if (tms_l) begin
                        ones_r <= (ones_r == `SEQ_ONES_MIN) ? ones_r : ones_r + 6'h01;
                    end else begin
                        ones_r <= 6'h00;
                        if (ones_r == `SEQ_ONES_MIN) begin
                            seq_r <= seq_pattern;
                            pat_r <= 16'h0000;
                            bits_r <= 5'h01;
                        end
                    end
                end
                seq_pattern: begin
                    pat_r <= {pat_r[14:0], tms_l};
                    bits_r <= bits_r + 5'h01;
                    if (bits_r == `SEQ_LEN - 5'h01) begin
                        if ({pat_r[14:0], tms_l} == `SEQ_PATTERN) begin
                            seq_r <= seq_tail;
                        end else begin
                            seq_r <= seq_count;
                        end
                    end
                end
                seq_tail: begin
                    if (!tms_l) begin
                        ones_r <= 6'h00;
                        seq_r <= seq_count;
                    end else if (ones_r == `SEQ_ONES_MIN - 6'h01) begin
                        sw_sel_r <= 1'b1;
                        ones_r <= `SEQ_ONES_MIN;
                        seq_r <= seq_count;
                    end else begin
                        ones_r <= ones_r + 6'h01;
                    end
                end
                default: seq_r <= seq_count;
            endcase
        end
    end

    // two taps in series: tdi, boundary tap, debug tap, tdo
    always_ff @(posedge test_clk_in) begin
        if (lrst) begin
            bs_st_r <= tap_reset;
            dbg_st_r <= tap_reset;
        end else begin
            bs_st_r <= tap_next(bs_st_r, bs_tms);
            dbg_st_r <= tap_next(dbg_st_r, tms_l);
        end
    end

    always_ff @(posedge test_clk_in) begin
        if (lrst || bs_st_r == tap_reset) begin
            bs_sh_r <= `BS_IR_CAP;
            bs_ir_out <= '1;
            bs_byp_r <= 1'b0;
        end else begin
            case (bs_st_r)
                tap_cap_ir: bs_sh_r <= `BS_IR_CAP;
                tap_shift_ir: bs_sh_r <= {tdi_l, bs_sh_r[`BS_IR_W-1:1]};
                tap_upd_ir: bs_ir_out <= bs_sh_r;
                tap_cap_dr: bs_byp_r <= 1'b0;
                tap_shift_dr: bs_byp_r <= tdi_l;
                default: bs_byp_r <= bs_byp_r;
            endcase
        end
    end

    always_ff @(posedge test_clk_in) begin
        if (lrst || dbg_st_r == tap_reset) begin
            dbg_sh_r <= `DBG_IR_CAP;
            dbg_ir_out <= '1;
            dbg_byp_r <= 1'b0;
        end else begin
            case (dbg_st_r)
                tap_cap_ir: dbg_sh_r <= `DBG_IR_CAP;
                // boundary tap bypassed after serial select, so the chain shrinks
                tap_shift_ir: dbg_sh_r <= {sw_sel_r ? tdi_l : bs_sh_r[0],
                                           dbg_sh_r[`DBG_IR_W-1:1]};
                tap_upd_ir: dbg_ir_out <= dbg_sh_r;
                tap_cap_dr: dbg_byp_r <= 1'b0;
                tap_shift_dr: dbg_byp_r <= sw_sel_r ? tdi_l : bs_dr;
                default: dbg_byp_r <= dbg_byp_r;
            endcase
        end
    end

    // tdo changes on the falling test clock edge
    always_ff @(negedge test_clk_in) begin
        if (lrst || sw_sel_r) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_out <= (dbg_st_r == tap_shift_ir) ? dbg_sh_r[0] : dbg_dr;
            tdo_oe_out <= (dbg_st_r == tap_shift_ir) || (dbg_st_r == tap_shift_dr);
        end
    end

endmodule : debug_pin_assign

// *** test/probe_model.sv ***
// debugger probe model: drives test clock, mode select and data in
// assumes the bench calls its tasks by hierarchical reference
`timescale 1ns/100ps
module probe_model (
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // lines idle at their pull levels, clock stands low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    task clk(input logic m);
        tms_out = m;
        #40 tck_out = 1'b1;
        #40 tck_out = 1'b0;
    endtask : clk

    task ones(input int n);
        repeat (n) clk(1'b1);
    endtask : ones

    // data out is sampled half a period after the falling edge that launched it
    task xfer(input logic m, input logic d, output logic q);
        tms_out = m;
        tdi_out = d;
        #40 q = tdo_in;
        tck_out = 1'b1;
        #40 tck_out = 1'b0;
    endtask : xfer

    // one instruction or data scan from idle or reset, ending in idle, lsb first
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        clk(1'b0);
        clk(1'b1);
        if (ir) clk(1'b1);
        clk(1'b0);
        clk(1'b0);
        for (int i = 0; i < n; i++) begin
            xfer(i == n - 1, din[i], q);
            dout[i] = q;
        end
        clk(1'b1);
        clk(1'b0);
        tdi_out = 1'b1;
    endtask : scan

    task switch_to_serial;
        logic [15:0] p;
        p = 16'h79E7;
        ones(52);
        for (int i = 15; i >= 0; i--) clk(p[i]);
        ones(52);
        tms_out = 1'b1;
    endtask : switch_to_serial
endmodule : probe_model

// *** test/debug_pin_chk.sv ***
// port-level assertions for the debug pin assignment block
// assumes debug_pin_cfg.svh is on the include path
`timescale 1ns/100ps
`include "debug_pin_cfg.svh"
module debug_pin_chk
    import debug_pin_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic sys_rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic bridge_full_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire pad_ctl_s gpio_ctl_in,
    input wire pad_ctl_s pad_ctl_out,
    input wire logic [4:0] debug_owns_out,
    input wire core_in_s core_in_out,
    input wire logic sw_mode_out,
    input wire logic tdo_oe_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    a_ready_one_shot: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_read_no_wait: assert property (psel_in && !penable_in && !pwrite_in |=> pready_out)
        else $error("read took a wait state");
    a_write_free: assert property (psel_in && !penable_in && pwrite_in && !bridge_full_in
        |=> pready_out)
        else $error("write waited with bridge not full");
    a_write_full_wait: assert property (psel_in && !penable_in && pwrite_in && bridge_full_in
        |=> !pready_out ##1 pready_out)
        else $error("full-bridge write not one wait");
    a_ident_read_only: assert property (psel_in && penable_in && pready_out && pwrite_in
        && paddr_in == `IDENT_ADDR |-> pslverr_out)
        else $error("identification write accepted");
    a_owned_pulls: assert property (((pad_ctl_out.pu ^ `DBG_PU) & debug_owns_out) == 5'h00
        && ((pad_ctl_out.pd ^ `DBG_PD) & debug_owns_out) == 5'h00
        && (pad_ctl_out.oe & debug_owns_out) == 5'h00)
        else $error("owned pin pad controls wrong");
    a_released_gpio: assert property (((pad_ctl_out ^ $past(gpio_ctl_in))
        & {4{~debug_owns_out}}) == 20'h00000)
        else $error("released pin not under gpio control");
    a_trst_tied: assert property (!debug_owns_out[`PIN_TRST] |-> core_in_out.trst_n)
        else $error("core test reset not tied high");
    a_tck_tied: assert property (!debug_owns_out[`PIN_TCK] |-> !core_in_out.tck)
        else $error("core test clock not tied low");
    a_tie_first: assert property ($fell(debug_owns_out[`PIN_TDI])
        |-> $past(core_in_out.tdi) && core_in_out.tdi)
        else $error("data in not tied before hand-over");
    a_sysrst_full: assert property (!sys_rst_n_in [*4] |-> debug_owns_out == 5'h1F)
        else $error("system reset left pins released");
    a_sw_quiet: assert property (sw_mode_out |-> !tdo_oe_out)
        else $error("boundary chain drives data out in serial mode");
endmodule : debug_pin_chk

bind debug_pin_assign debug_pin_chk i_chk (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .sys_rst_n_in(sys_rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .bridge_full_in(bridge_full_in),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .gpio_ctl_in(gpio_ctl_in),
    .pad_ctl_out(pad_ctl_out),
    .debug_owns_out(debug_owns_out),
    .core_in_out(core_in_out),
    .sw_mode_out(sw_mode_out),
    .tdo_oe_out(tdo_oe_out)
);

// *** test/debug_pin_assign_test.sv ***
// self-checking bench for the debug pin assignment block
// assumes probe_model and the bound checker are compiled alongside
`timescale 1ns/100ps
module debug_pin_assign_test;
    import debug_pin_pkg::*;
    localparam logic [15:0] REV = 16'h00C3; // arbitrary value
    localparam logic [11:0] DEVC = 12'h05A; // arbitrary value
    localparam logic [31:0] IDENT_EXP = {REV, 4'h0, DEVC};
    localparam logic [2:0] CFGS [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0};
    localparam logic [4:0] OWNS [5] = '{5'h0F, 5'h03, 5'h00, 5'h1F, 5'h1F};
    logic clock_in, nrst_in, sys_rst_n_in, psel_in, penable_in, pwrite_in, bridge_full_in;
    logic [31:0] paddr_in, pwdata_in, prdata_out;
    logic pready_out, pslverr_out, trst_line, sw_mode_out, tdo_out, tdo_oe_out, tck, tms, tdi;
    pad_ctl_s gpio_ctl_in, pad_ctl_out, ep;
    logic [4:0] debug_owns_out, bs_ir_out;
    logic [3:0] dbg_ir_out;
    core_in_s core_in_out;
    logic [31:0] r;
    logic e;
    int w, failures, check_count;

    probe_model i_probe (.tdo_in(tdo_out), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
    debug_pin_assign #(.REV_CODE(REV), .DEV_CODE(DEVC)) i_dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .sys_rst_n_in(sys_rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .bridge_full_in(bridge_full_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .pin_in({trst_line, 1'b0, tdi, tck, tms}), .gpio_ctl_in(gpio_ctl_in),
        .pad_ctl_out(pad_ctl_out), .debug_owns_out(debug_owns_out),
        .core_in_out(core_in_out), .sw_mode_out(sw_mode_out), .test_clk_in(tck),
        .bs_dr_tdo_in(1'b0), .dbg_dr_tdo_in(1'b0), .bs_ir_out(bs_ir_out),
        .dbg_ir_out(dbg_ir_out), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic full);
        @(negedge clock_in);
        psel_in = 1'b1;
        penable_in = 1'b0;
        pwrite_in = wr;
        paddr_in = a;
        pwdata_in = d;
        bridge_full_in = full;
        @(negedge clock_in);
        penable_in = 1'b1;
        w = 0;
        while (pready_out !== 1'b1 && w < 8) begin
            @(negedge clock_in);
            w++;
        end
        r = prdata_out;
        e = pslverr_out;
        @(negedge clock_in);
        psel_in = 1'b0;
        penable_in = 1'b0;
        bridge_full_in = 1'b0;
    endtask : bus

    task t_reset_state;
        chk("owns", 32'h1F, debug_owns_out);
        chk("pad pulls", {22'h0, 5'h15, 5'h02}, {22'h0, pad_ctl_out.pu, pad_ctl_out.pd});
        chk("sw mode", 32'h0, sw_mode_out);
        chk("instructions", 32'h1FF, {bs_ir_out, dbg_ir_out});
        bus(1'b0, 32'h40010004, 32'h0, 1'b0);
        chk("remap", 32'h0, r);
        chk("read waits", 32'h0, w);
        bus(1'b0, 32'hE0042000, 32'h0, 1'b0);
        chk("ident", IDENT_EXP, r);
    endtask : t_reset_state

    // link leaves its reset after two test clocks; taps stay in reset on ones
    task t_scan_chain;
        i_probe.ones(5);
        i_probe.scan(1'b1, 9, {23'h0, 5'h1F, 4'hE}, r);
        chk("ir capture", 32'h011, r);
        chk("chained ir", 32'h1FE, {bs_ir_out, dbg_ir_out});
        i_probe.scan(1'b1, 9, 32'h1FF, r);
        i_probe.scan(1'b0, 8, 32'hA5, r);
        chk("bypass delay", 32'h94, r);
    endtask : t_scan_chain

    task t_bus_rules;
        bus(1'b1, 32'h40010004, 32'h02000000, 1'b1);
        chk("full write waits", 32'h1, w);
        bus(1'b1, 32'h40010004, 32'h0, 1'b0);
        chk("free write waits", 32'h0, w);
        bus(1'b1, 32'hE0042000, 32'hFFFFFFFF, 1'b0);
        chk("ident write error", 32'h1, e);
        bus(1'b0, 32'hE0042000, 32'h0, 1'b0);
        chk("ident kept", IDENT_EXP, r);
        bus(1'b0, 32'h40010008, 32'h0, 1'b0);
        chk("unmapped error", 32'h1, e);
    endtask : t_bus_rules

    task t_modes;
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 32'h40010004, {5'h0, CFGS[i], 24'h0}, 1'b0);
            repeat (5) @(negedge clock_in);
            chk("mode owns", OWNS[i], debug_owns_out);
            ep.out = gpio_ctl_in.out & ~OWNS[i];
            ep.oe = gpio_ctl_in.oe & ~OWNS[i];
            ep.pu = (5'h15 & OWNS[i]) | (gpio_ctl_in.pu & ~OWNS[i]);
            ep.pd = (5'h02 & OWNS[i]) | (gpio_ctl_in.pd & ~OWNS[i]);
            chk("pad controls", {12'h0, ep}, {12'h0, pad_ctl_out});
            bus(1'b0, 32'h40010004, 32'h0, 1'b0);
            chk("cfg readback", {5'h0, CFGS[i], 24'h0}, r);
            if (i == 0) begin
                trst_line = 1'b0;
                repeat (3) @(negedge clock_in);
                chk("core trst tied", 32'h1, core_in_out.trst_n);
                trst_line = 1'b1;
            end
        end
    endtask : t_modes

    task t_sysrst_switch;
        bus(1'b1, 32'h40010004, 32'h02000000, 1'b0);
        repeat (5) @(negedge clock_in);
        chk("serial owns", 32'h03, debug_owns_out);
        sys_rst_n_in = 1'b0;
        i_probe.switch_to_serial();
        chk("sysrst owns", 32'h1F, debug_owns_out);
        bus(1'b0, 32'h40010004, 32'h0, 1'b0);
        chk("sysrst cfg", 32'h0, r);
        bus(1'b0, 32'hE0042000, 32'h0, 1'b0);
        chk("ident in sysrst", IDENT_EXP, r);
        sys_rst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        chk("sw mode set", 32'h1, sw_mode_out);
        chk("tdo quiet", 32'h0, tdo_oe_out);
        chk("boundary held", 32'h1F, bs_ir_out);
        bus(1'b1, 32'h40010004, 32'h02000000, 1'b0);
        repeat (5) @(negedge clock_in);
        chk("serial after switch", 32'h03, debug_owns_out);
    endtask : t_sysrst_switch

    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial begin
        #200000;
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        check_count = 0;
        {nrst_in, psel_in, penable_in, pwrite_in, bridge_full_in} = 5'h00;
        {sys_rst_n_in, trst_line} = 2'h3;
        paddr_in = 32'h0;
        pwdata_in = 32'h0;
        gpio_ctl_in = '{5'h0A, 5'h13, 5'h0C, 5'h11};
        fork
            i_probe.ones(4);
            repeat (6) @(negedge clock_in);
        join
        nrst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        t_reset_state();
        t_scan_chain();
        t_bus_rules();
        t_modes();
        t_sysrst_switch();
        conclude();
    end
endmodule : debug_pin_assign_test
